/* File: hw/nbpr_host.sv */
// Purpose: Host controller driving a NAND flash for page reads
// Assumes: Pins from flash pass two flip-flops; read cycle of at least 30 ns
// Notes:   Read-only host: write protect is held active at all times
// Summary of operation
// - Data port is 8 or 16 lines
// - Command latch high marks a command byte
// - Address latch high marks an address byte
// - Four address cycles, column then row
// - Word-wide variant uses low byte only
// - Read is 00h, address, 30h, busy
// - Read out only after ready
// - Fast read cycles need extended output timing
// - Column jump is 05h, two columns, E0h
`timescale 1ns/1ps
module nbpr_host #(
  parameter int unsigned DATA_W     = 8,
  parameter int unsigned FIFO_DEPTH = nbpr_pkg::FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_jump,
  input  wire logic [11:0]       cmd_column,
  input  wire logic [15:0]       cmd_row,
  input  wire logic [10:0]       cmd_count,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic      [DATA_W-1:0] out_data,
  output logic                   ctrl_busy,
  output logic                   flash_ce_n,
  output logic                   flash_cle,
  output logic                   flash_ale,
  output logic                   flash_we_n,
  output logic                   flash_re_n,
  output logic                   flash_wp_n,
  output logic                   whole_chip_protect,
  output logic      [DATA_W-1:0] shared_data_port_out,
  output logic                   shared_data_port_oe,
  input  wire logic [DATA_W-1:0] shared_data_port_in,
  input  wire logic              flash_busy_n
);
  initial
  begin
    if (DATA_W != 8 && DATA_W != 16)
      $error("nbpr_host: DATA_W must be 8 or 16");
    if (nbpr_pkg::READ_CYCLE_NS < nbpr_pkg::T_CYCLE_EDO_NS)
      $error("nbpr_host: read cycle too short for plain output timing");
    if (nbpr_pkg::WB_CYC > 255 || nbpr_pkg::RE_LOW_CYC > 255)
      $error("nbpr_host: timer too narrow");
  end

  typedef enum logic [2:0] {
    NBPR_IDLE    = 3'b000,
    NBPR_WR_LOW  = 3'b001,
    NBPR_WR_HIGH = 3'b010,
    NBPR_WAIT_WB = 3'b011,
    NBPR_WAIT_RB = 3'b100,
    NBPR_RD_LOW  = 3'b101,
    NBPR_RD_HIGH = 3'b110
  } nbpr_state_e;

  localparam logic [11:0] COL_MASK =
    (DATA_W == 8) ? nbpr_pkg::COL_MASK_X8 : nbpr_pkg::COL_MASK_X16;
  localparam logic [11:0] MAX_WORDS = (DATA_W == 8) ?
    12'(nbpr_pkg::PAGE_BYTES) : 12'(nbpr_pkg::PAGE_WORDS);

  nbpr_state_e      state;
  nbpr_state_e      next_state;
  logic [7:0]       timer;
  logic [7:0]       next_timer;
  logic [2:0]       step;
  logic [2:0]       next_step;
  logic [10:0]      words_left;
  logic [10:0]      next_words_left;
  logic [11:0]      col;
  logic [11:0]      next_col;
  logic [15:0]      row;
  logic [15:0]      next_row;
  logic             jump;
  logic             next_jump;
  logic             ce_n;
  logic             next_ce_n;
  logic             cle;
  logic             next_cle;
  logic             ale;
  logic             next_ale;
  logic             we_n;
  logic             next_we_n;
  logic             re_n;
  logic             next_re_n;
  logic [DATA_W-1:0] dq_out;
  logic [DATA_W-1:0] next_dq_out;
  logic             dq_oe;
  logic             next_dq_oe;
  logic             push;
  logic             busy_meta;
  logic             busy_sync_n;
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic             fifo_in_ready;
  logic [2:0]       last_step;
  logic [7:0]       step_byte;
  logic             step_is_cmd;
  logic [2:0]       follow_step;

  // Two-stage synchronisers for pins; left unreset, the reset hold flushes them
  always_ff @(posedge sys_clk)
  begin
    busy_meta   <= flash_busy_n;
    busy_sync_n <= busy_meta;
    dq_meta     <= shared_data_port_in;
    dq_sync     <= dq_meta;
  end

  // Byte and latch kind of the bus write after the current one
  always_comb
  begin
    last_step   = jump ? nbpr_pkg::LAST_STEP_JUMP : nbpr_pkg::LAST_STEP_READ;
    follow_step = step + 3'h1;
    step_is_cmd = (follow_step == last_step);
    step_byte   = 8'h00;
    case (follow_step)
      3'h1: step_byte = col[7:0];
      3'h2: step_byte = {4'h0, col[11:8]};
      3'h3: step_byte = jump ? nbpr_pkg::CMD_JUMP_CONFIRM : row[7:0];
      3'h4: step_byte = row[15:8];
      3'h5: step_byte = nbpr_pkg::CMD_READ_CONFIRM;
      default: step_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    next_state      = state;
    next_timer      = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
    next_step       = step;
    next_words_left = words_left;
    next_col        = col;
    next_row        = row;
    next_jump       = jump;
    next_ce_n       = ce_n;
    next_cle        = cle;
    next_ale        = ale;
    next_we_n       = we_n;
    next_re_n       = re_n;
    next_dq_out     = dq_out;
    next_dq_oe      = dq_oe;
    case (state)
      NBPR_IDLE:
      begin
        next_ce_n = 1'b1;
        if (cmd_valid)
        begin
          next_jump       = cmd_jump;
          next_col        = cmd_column & COL_MASK;
          next_row        = cmd_row;
          // Count port tops out at 2047, so a full byte-wide page takes two commands
          next_words_left = ({1'b0, cmd_count} > MAX_WORDS) ? MAX_WORDS[10:0] : cmd_count;
          next_step       = 3'h0;
          next_ce_n       = 1'b0;
          next_state      = NBPR_WR_LOW;
          next_timer      = 8'(nbpr_pkg::WE_LOW_CYC - 1);
          next_we_n       = 1'b0;
          next_dq_oe      = 1'b1;
          next_cle        = 1'b1;
          next_ale        = 1'b0;
          next_dq_out     = DATA_W'(cmd_jump ? nbpr_pkg::CMD_JUMP_SETUP
                                             : nbpr_pkg::CMD_READ_SETUP);
        end
      end
      NBPR_WR_LOW:
      begin
        if (timer == 8'h00)
        begin
          // Rising edge latches the byte; data and latches stay put
          next_we_n  = 1'b1;
          next_timer = 8'(nbpr_pkg::WE_HIGH_CYC - 1);
          next_state = NBPR_WR_HIGH;
        end
      end
      NBPR_WR_HIGH:
      begin
        if (timer == 8'h00)
        begin
          if (step == last_step)
          begin
            next_cle   = 1'b0;
            next_ale   = 1'b0;
            next_dq_oe = 1'b0;
            next_timer = 8'(nbpr_pkg::WB_CYC - 1);
            next_state = NBPR_WAIT_WB;
          end
          else
          begin
            next_step   = follow_step;
            next_we_n   = 1'b0;
            next_cle    = step_is_cmd;
            next_ale    = !step_is_cmd;
            next_dq_out = DATA_W'(step_byte);
            next_timer  = 8'(nbpr_pkg::WE_LOW_CYC - 1);
            next_state  = NBPR_WR_LOW;
          end
        end
      end
      NBPR_WAIT_WB:
      begin
        // Busy pin needs time to fall after the confirm byte
        if (timer == 8'h00)
        begin
          if (jump)
            next_state = NBPR_RD_HIGH;
          else
          begin
            next_ce_n  = 1'b1;
            next_state = NBPR_WAIT_RB;
          end
        end
      end
      NBPR_WAIT_RB:
      begin
        if (busy_sync_n)
        begin
          next_ce_n  = 1'b0;
          next_timer = 8'(nbpr_pkg::RE_HIGH_CYC - 1);
          next_state = NBPR_RD_HIGH;
        end
      end
      NBPR_RD_HIGH:
      begin
        if (timer == 8'h00)
        begin
          if (words_left == 11'h000)
            next_state = NBPR_IDLE;
          else if (fifo_in_ready)
          begin
            // Strobe only with room saved for the word
            next_re_n  = 1'b0;
            next_timer = 8'(nbpr_pkg::RE_LOW_CYC - 1);
            next_state = NBPR_RD_LOW;
          end
        end
      end
      NBPR_RD_LOW:
      begin
        if (timer == 8'h00)
        begin
          next_re_n       = 1'b1;
          next_words_left = words_left - 11'h001;
          next_timer      = 8'(nbpr_pkg::RE_HIGH_CYC - 1);
          next_state      = NBPR_RD_HIGH;
        end
      end
      default:
        next_state = NBPR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state      <= NBPR_IDLE;
      timer      <= 8'h00;
      step       <= 3'h0;
      words_left <= 11'h000;
      col        <= 12'h000;
      row        <= 16'h0000;
      jump       <= 1'b0;
      ce_n       <= 1'b1;
      cle        <= 1'b0;
      ale        <= 1'b0;
      we_n       <= 1'b1;
      re_n       <= 1'b1;
      dq_out     <= '0;
      dq_oe      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      timer      <= next_timer;
      step       <= next_step;
      words_left <= next_words_left;
      col        <= next_col;
      row        <= next_row;
      jump       <= next_jump;
      ce_n       <= next_ce_n;
      cle        <= next_cle;
      ale        <= next_ale;
      we_n       <= next_we_n;
      re_n       <= next_re_n;
      dq_out     <= next_dq_out;
      dq_oe      <= next_dq_oe;
    end
  end

  nbpr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (dq_sync),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign cmd_ready            = (state == NBPR_IDLE);
  assign ctrl_busy            = (state != NBPR_IDLE);
  assign push                 = (state == NBPR_RD_LOW) && (timer == 8'h00);
  assign flash_ce_n           = ce_n;
  assign flash_cle            = cle;
  assign flash_ale            = ale;
  assign flash_we_n           = we_n;
  assign flash_re_n           = re_n;
  // Read-only host never unlocks program or erase
  assign flash_wp_n           = 1'b0;
  assign whole_chip_protect   = 1'b0;
  assign shared_data_port_out = dq_out;
  assign shared_data_port_oe  = dq_oe;
endmodule

/* File: hw/nbpr_pkg.sv */
// Purpose: Shared constants for the NAND page read host controller
// Assumes: 250 MHz sys_clk, 4 ns period
// Notes:   Times are in ns; cycle counts are derived from them
package nbpr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SYNC_STAGES   = 2;

  // Command bytes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_JUMP_SETUP   = 8'h05;
  localparam logic [7:0] CMD_JUMP_CONFIRM = 8'he0;

  // Page geometry
  localparam int unsigned PAGE_BYTES      = 2112;
  localparam int unsigned PAGE_WORDS      = 1056;
  localparam int unsigned PAGES_PER_BLOCK = 64;

  // Column masks for the two bus widths
  localparam logic [11:0] COL_MASK_X8  = 12'hfff;
  localparam logic [11:0] COL_MASK_X16 = 12'h7ff;

  // Step positions of the last bus write in each sequence
  localparam logic [2:0] LAST_STEP_READ = 3'h5;
  localparam logic [2:0] LAST_STEP_JUMP = 3'h3;

  // Strobe timing
  localparam int unsigned T_WE_LOW_NS   = 12;
  localparam int unsigned T_WE_HIGH_NS  = 12;
  localparam int unsigned T_REA_NS      = 20;
  localparam int unsigned T_RE_HIGH_NS  = 12;
  localparam int unsigned T_WB_NS       = 100;
  localparam int unsigned T_CYCLE_EDO_NS = 30;

  localparam int unsigned WE_LOW_CYC  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read strobe stays low until the synchronised data is settled
  localparam int unsigned RE_LOW_CYC  =
    (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int unsigned RE_HIGH_CYC = (T_RE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WB_CYC      = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYCLE_NS = (RE_LOW_CYC + RE_HIGH_CYC) * CLK_PERIOD_NS;

  localparam int unsigned FIFO_DEPTH = 8;
endpackage

/* File: hw/nbpr_fifo.sv */
// Purpose: Small synchronous FIFO between flash reads and the user
// Assumes: One clock, synchronous active-high reset
// Notes:   DEPTH must be a power of two
`timescale 1ns/1ps
module nbpr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("nbpr_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  always_comb
  begin
    do_wr       = in_valid && in_ready;
    do_rd       = out_valid && out_ready;
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_fill   = fill;
    if (do_wr && !do_rd)
      next_fill = fill + 1'b1;
    else if (do_rd && !do_wr)
      next_fill = fill - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end
endmodule

/* File: test/nbpr_host_assertions.sv */
// Purpose: Port checks for the page read host
// Assumes: One clock, synchronous active-high reset
// Notes:   Strobe widths are the 3 and 7 cycle choices
`timescale 1ns/1ps
module nbpr_host_chk #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic              cmd_jump,
  input wire logic              flash_ce_n,
  input wire logic              flash_cle,
  input wire logic              flash_ale,
  input wire logic              flash_we_n,
  input wire logic              flash_re_n,
  input wire logic              flash_wp_n,
  input wire logic              whole_chip_protect,
  input wire logic [DATA_W-1:0] shared_data_port_out,
  input wire logic              shared_data_port_oe,
  input wire logic              flash_busy_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_latch_excl; !(flash_cle && flash_ale); endproperty
  property p_read_quiet;
    !flash_re_n |-> !flash_cle && !flash_ale && !shared_data_port_oe && !flash_ce_n;
  endproperty
  property p_protect_low; !flash_wp_n && !whole_chip_protect; endproperty
  property p_we_edge;
    $rose(flash_we_n) |-> $stable(shared_data_port_out) && $stable(flash_cle)
      && $stable(flash_ale) && shared_data_port_oe;
  endproperty
  property p_we_width; $fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n; endproperty
  property p_re_width; $fell(flash_re_n) |-> !flash_re_n [*7] ##1 flash_re_n; endproperty
  // Busy pin passes two flops, so ready must be old news
  property p_re_ready; $fell(flash_re_n) |-> flash_busy_n && $past(flash_busy_n, 3); endproperty
  property p_first_byte;
    cmd_valid && cmd_ready |=> !cmd_ready && flash_cle && !flash_we_n && !flash_ce_n
      && shared_data_port_oe && shared_data_port_out[7:0] == ($past(cmd_jump) ? 8'h05 : 8'h00);
  endproperty
  property p_idle_standby; cmd_ready && $past(cmd_ready) |-> flash_ce_n; endproperty

  a_latch_excl: assert property (p_latch_excl)
    else $error("command and address latch high together");
  a_read_quiet: assert property (p_read_quiet)
    else $error("latch or drive active during read strobe");
  a_protect_low: assert property (p_protect_low)
    else $error("protect pins not held low");
  a_we_edge: assert property (p_we_edge)
    else $error("bus changed at write strobe rise");
  a_we_width: assert property (p_we_width)
    else $error("write strobe low width wrong");
  a_re_width: assert property (p_re_width)
    else $error("read strobe low width wrong");
  a_re_ready: assert property (p_re_ready)
    else $error("read strobe while device busy");
  a_first_byte: assert property (p_first_byte)
    else $error("wrong first command byte");
  a_idle_standby: assert property (p_idle_standby)
    else $error("chip select held while idle");

  c_jump: cover property (cmd_valid && cmd_ready && cmd_jump);
  c_strobe: cover property ($fell(flash_re_n));
  c_busy_free: cover property (!flash_busy_n && flash_ce_n);
endmodule

bind nbpr_host nbpr_host_chk #(.DATA_W(DATA_W)) chk_u (
  .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_jump, .flash_ce_n, .flash_cle,
  .flash_ale, .flash_we_n, .flash_re_n, .flash_wp_n, .whole_chip_protect,
  .shared_data_port_out, .shared_data_port_oe, .flash_busy_n
);

/* File: test/nbpr_flash_model.sv */
// Purpose: Behavioural byte-wide flash seen by the host
// Assumes: Pin-driven, no clock; page data is column plus page row
// Notes:   Released bus shows the inverse so stale data never matches
`timescale 1ns/1ps
module nbpr_flash_model (
  input  wire logic       flash_ce_n,
  input  wire logic       flash_cle,
  input  wire logic       flash_ale,
  input  wire logic       flash_we_n,
  input  wire logic       flash_re_n,
  input  wire logic [7:0] shared_data_port_out,
  input  wire logic       slow_busy,
  output logic      [7:0] shared_data_port_in,
  output logic            flash_busy_n
);
  logic [7:0]  cmd;
  logic [2:0]  addr_cnt;
  logic [11:0] col;
  logic [15:0] row;
  logic [15:0] page_row;
  initial
  begin
    cmd = 8'hff;
    addr_cnt = 3'h0;
    col = 12'h000;
    row = 16'h0000;
    page_row = 16'h0000;
    flash_busy_n = 1'b1;
    shared_data_port_in = 8'h00;
  end
  always @(posedge flash_we_n)
  begin
    if (!flash_ce_n && flash_cle)
    begin
      if (shared_data_port_out == 8'h30 && cmd == 8'h00 && addr_cnt == 3'h4)
      begin
        page_row = row;
        flash_busy_n = 1'b0;
        // Runs to the end whatever chip select does meanwhile
        flash_busy_n <= #(slow_busy ? 2000 : 200) 1'b1;
      end
      cmd = shared_data_port_out;
      addr_cnt = 3'h0;
    end
    else if (!flash_ce_n && flash_ale)
    begin
      case (addr_cnt)
        3'h0: col[7:0] = shared_data_port_out;
        3'h1: col[11:8] = shared_data_port_out[3:0];
        3'h2: row[7:0] = shared_data_port_out;
        default: row[15:8] = shared_data_port_out;
      endcase
      addr_cnt = addr_cnt + 3'h1;
    end
  end
  // Deselected or busy: no new word, bus keeps the inverted pattern
  always @(negedge flash_re_n)
  begin
    if (!flash_ce_n && flash_busy_n)
    begin
      shared_data_port_in <= #16 col[7:0] + page_row[7:0];
      col = col + 12'h001;
    end
  end
  always @(posedge flash_re_n)
    shared_data_port_in <= #6 ~shared_data_port_in;
endmodule

/* File: test/test_nand_bus_page_read.sv */
// Purpose: Self-checking bench for the page read host
// Assumes: Byte-wide host against the behavioural flash
// Notes:   Outputs are judged at the falling clock edge
`timescale 1ns/1ps
module test_nand_bus_page_read;
  logic        sys_clk, reset, cmd_valid, cmd_jump, out_ready, slow_busy;
  logic        cmd_ready, out_valid, ctrl_busy, flash_ce_n, flash_cle, flash_ale;
  logic        flash_we_n, flash_re_n, flash_wp_n, whole_chip_protect;
  logic        shared_data_port_oe, flash_busy_n;
  logic [11:0] cmd_column;
  logic [15:0] cmd_row, last_row;
  logic [10:0] cmd_count;
  logic [7:0]  out_data, shared_data_port_out, shared_data_port_in;
  int          bad_count, checked;

  nbpr_host #(.DATA_W(8), .FIFO_DEPTH(8)) dut_u (
    .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_jump, .cmd_column, .cmd_row,
    .cmd_count, .out_valid, .out_ready, .out_data, .ctrl_busy, .flash_ce_n,
    .flash_cle, .flash_ale, .flash_we_n, .flash_re_n, .flash_wp_n,
    .whole_chip_protect, .shared_data_port_out, .shared_data_port_oe,
    .shared_data_port_in, .flash_busy_n
  );
  nbpr_flash_model flash_u (
    .flash_ce_n, .flash_cle, .flash_ale, .flash_we_n, .flash_re_n,
    .shared_data_port_out, .slow_busy, .shared_data_port_in, .flash_busy_n
  );

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Jumps keep the buffered page, so expectations use the last page row
  task automatic run(input logic jump, input logic [11:0] col, input logic [15:0] row,
                     input logic [10:0] cnt, input int stall);
    int          got;
    int          n;
    logic [11:0] c;
    got = 0;
    n = 0;
    c = col;
    if (!jump)
      last_row = row;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_jump <= jump;
    cmd_column <= col;
    cmd_row <= row;
    cmd_count <= cnt;
    if (stall > 0)
      out_ready <= 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (stall) @(negedge sys_clk);
    if (stall > 0)
      check(out_valid === 1'b1 && ctrl_busy === 1'b1, "host ran on past full buffer");
    @(posedge sys_clk);
    out_ready <= 1'b1;
    while (got < cnt && n < 40000)
    begin
      @(negedge sys_clk);
      n++;
      if (out_valid === 1'b1 && out_ready === 1'b1)
      begin
        check(out_data === c[7:0] + last_row[7:0], "wrong data word");
        c = c + 12'h001;
        got++;
      end
    end
    check(got == cnt, "too few words");
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    repeat (2) @(negedge sys_clk);
    check(out_valid === 1'b0 && flash_ce_n === 1'b1, "not idle after command");
    check(flash_wp_n === 1'b0 && whole_chip_protect === 1'b0, "protect");
  endtask

  task automatic t_single();
    run(1'b0, 12'h000, 16'h1234, 11'h001, 0);
  endtask

  task automatic t_page_end();
    run(1'b0, 12'h83c, 16'h00a5, 11'h004, 0);
    run(1'b0, 12'h7f0, 16'h0021, 11'h050, 0);
  endtask

  // Long busy and a full buffer: reads wait for ready, strobes stall
  task automatic t_stall_slow();
    slow_busy <= 1'b1;
    run(1'b0, 12'h100, 16'h0f0f, 11'h00c, 900);
    slow_busy <= 1'b0;
  endtask

  task automatic t_jump();
    run(1'b0, 12'h020, 16'h0033, 11'h002, 0);
    run(1'b1, 12'h010, 16'hffff, 11'h003, 0);
  endtask

  task automatic t_zero();
    run(1'b0, 12'h004, 16'h0002, 11'h000, 0);
  endtask

  task automatic t_reset_mid();
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_jump <= 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(flash_ce_n === 1'b1 && flash_we_n === 1'b1 && cmd_ready === 1'b1, "reset");
    run(1'b0, 12'h7ff, 16'h0101, 11'h002, 0);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    #200000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_jump = 1'b0;
    cmd_column = 12'h000;
    cmd_row = 16'h0000;
    cmd_count = 11'h000;
    out_ready = 1'b1;
    slow_busy = 1'b0;
    last_row = 16'h0000;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_single();
    t_page_end();
    t_stall_slow();
    t_jump();
    t_zero();
    t_reset_mid();
    summarize();
  end
endmodule
